// file: pgr_pkg.sv
/*
 Package for the parameter guard and restart limit block: register map,
 field layouts, reset values and limit constants.
 Assumes a 32-bit APB bus with word-aligned registers.
*/
package pgr_pkg;
    localparam int unsigned PGR_AW = 8;
    // Register byte offsets
    localparam logic [7:0] PGR_OFS_CMD     = 8'h00;
    localparam logic [7:0] PGR_OFS_WDATA   = 8'h04;
    localparam logic [7:0] PGR_OFS_RESULT  = 8'h08;
    localparam logic [7:0] PGR_OFS_RDATA   = 8'h0c;
    localparam logic [7:0] PGR_OFS_STATUS  = 8'h10;
    localparam logic [7:0] PGR_OFS_IRQ_ST  = 8'h14;
    localparam logic [7:0] PGR_OFS_IRQ_MSK = 8'h18;
    localparam logic [7:0] PGR_OFS_CONTROL = 8'h1c;
    localparam logic [7:0] PGR_OFS_RESTART = 8'h20;
    localparam logic [7:0] PGR_OFS_BUSADDR = 8'h24;

    localparam int unsigned PGR_NPARAM = 8;
    localparam int unsigned PGR_IDX_W  = 3;

    // Command word fields
    localparam int unsigned CMD_IDX_LSB = 0;
    localparam int unsigned CMD_OP_LSB  = 4;
    localparam int unsigned CMD_PC_BIT  = 8;
    localparam int unsigned CMD_LVL_LSB = 12;
    localparam logic [3:0] OP_READ      = 4'h0;
    localparam logic [3:0] OP_WRITE     = 4'h1;
    localparam logic [3:0] OP_SET_LO    = 4'h2;
    localparam logic [3:0] OP_SET_HI    = 4'h3;
    localparam logic [3:0] OP_RELEASE   = 4'h4;

    // Result codes
    localparam logic [3:0] RES_OK       = 4'h0;
    localparam logic [3:0] RES_LEVEL    = 4'h1;
    localparam logic [3:0] RES_RANGE    = 4'h2;
    localparam logic [3:0] RES_PATH     = 4'h3;
    localparam logic [3:0] RES_FIXED    = 4'h4;
    localparam logic [3:0] RES_RUNNING  = 4'h5;
    localparam logic [3:0] RES_BADOP    = 4'h6;

    localparam logic [1:0] LVL_INTEGRATOR = 2'h1;
    localparam logic [1:0] LVL_EXPERT     = 2'h2;

    localparam logic [7:0] ERR_NONE      = 8'h00;
    localparam logic [7:0] ERR_BUSADDR   = 8'h12;
    localparam logic [7:0] ERR_UNRELEASE = 8'h3c;

    localparam logic [8:0] BUSADDR_OFF   = 9'h1ff;
    localparam logic [8:0] BUSADDR_MAX   = 9'h0fe;
    localparam logic [2:0] RESTART_MAX   = 3'h5;

    // Interrupt status bits
    localparam int unsigned IRQ_F60    = 0;
    localparam int unsigned IRQ_F18    = 1;
    localparam int unsigned IRQ_LOCK   = 2;
    localparam int unsigned IRQ_REJECT = 3;
    localparam int unsigned IRQ_BUSMSG = 4;
    localparam int unsigned IRQ_W      = 5;

    typedef enum logic [1:0] {
        PGR_W1  = 2'h0,
        PGR_W8  = 2'h1,
        PGR_W16 = 2'h2
    } pgr_width_t;
endpackage

// file: pgr_param_guard.sv
/*
 Parameter guard and restart limits: parameter table with access levels and
 limits, unreleased change watch, bus address check, restart counters.
 Assumes an APB master on pclk and sequence events already synchronous to pclk.
*/
// How it works
// - Parameters are one bit, one byte or sixteen bits; single bits have no limits.
// - A change is refused unless the requester holds the parameter's access level.
// - A value outside the current lower and upper limits is rejected.
// - Limits change only at level 2 and only over the PC path.
// - Every variable limit must stay inside fixed outer limits.
// - Parameters locked during operation change only while waiting for heat request.
// - In automatic mode an unreleased change causes interlock with error F 60.
// - Integrator level or higher may release directly while staying in automatic.
// - Bus address accepts off or an integer from 0 to 254.
// - Invalid bus address in parameter mode only raises an error message.
// - Left arrow on operating or error display presents the current bus address; here only operating_display gates show_bus_address.
// - Restart limit is 0 to 5; a failed final restart locks out non-volatile; here presetn clears lock as well as unlock_event.
// - Anti-oscillation counter clears on entering operation or on unlock.
// - A separate 0 to 5 limit bounds restarts after no flame at start-up.
// - Restart and anti-oscillation counters reset on operation or unlock.
`timescale 1ns/1ps
module pgr_param_guard #(
    parameter int unsigned NPARAM = pgr_pkg::PGR_NPARAM
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [pgr_pkg::PGR_AW-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     auto_mode_pin,
    input  wire logic                     left_arrow_pin,
    input  wire logic                     state_waiting_heat,
    input  wire logic                     state_operating,
    input  wire logic                     unlock_event,
    input  wire logic                     restart_request,
    input  wire logic                     restart_startup_noflame,
    input  wire logic                     manual_run_done,
    input  wire logic                     operating_display,
    input  wire logic                     bus_module_max_valid,
    output logic                          malfunction_interlock,
    output logic                          restart_initiate,
    output logic                          lockout,
    output logic      [7:0]               error_code,
    output logic                          show_bus_address,
    output logic                          irq
);
    import pgr_pkg::*;

    // The command index field is three bits wide, so more than eight entries cannot be reached
    if (NPARAM < 4 || NPARAM > 8) begin : g_nparam_check
        $error("NPARAM must be 4..8");
    end

    // Fixed per-parameter attributes: width, level, locked in operation, fixed bounds
    function automatic pgr_width_t pwidth(input logic [2:0] i);
        return (i == 3'h0) ? PGR_W1 : (i[0] ? PGR_W16 : PGR_W8);
    endfunction
    function automatic logic [15:0] fixed_hi(input logic [2:0] i);
        return (pwidth(i) == PGR_W16) ? 16'hffff : 16'h00ff;
    endfunction
    function automatic logic [1:0] plevel(input logic [2:0] i);
        return (i == 3'h0) ? LVL_INTEGRATOR : 2'h0;
    endfunction
    function automatic logic locked_in_op(input logic [2:0] i);
        return i[1];
    endfunction

    typedef struct packed {
        logic [NPARAM-1:0][15:0] val;
        logic [NPARAM-1:0][15:0] lo;
        logic [NPARAM-1:0][15:0] hi;
        logic [NPARAM-1:0][15:0] rel;
        logic [31:0]             wdata;
        logic [3:0]              result;
        logic [15:0]             rdata;
        logic [1:0]              level;
        logic [8:0]              busaddr;
        logic [2:0]              lim_all;
        logic [2:0]              lim_start;
        logic [2:0]              cnt_all;
        logic [2:0]              cnt_start;
        logic                    lock;
        logic                    f60;
        logic                    f18;
        logic                    busmsg;
        logic [IRQ_W-1:0]        ist;
        logic [IRQ_W-1:0]        imsk;
        logic [1:0]              auto_s;
        logic [1:0]              arrow_s;
        logic                    restart_o;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    irq;
        logic                    show;
        logic [7:0]              err;
    } pgr_state_t;

    pgr_state_t st_r;
    pgr_state_t st_nxt;

    logic        wr_acc;
    logic        rd_acc;
    logic [2:0]  cidx;
    logic [3:0]  cop;
    logic        cpc;
    logic [1:0]  clvl;
    logic [15:0] cval;
    logic        auto_m;
    logic        mapped;
    logic        addr_bad;
    logic [IRQ_W-1:0] ev;
    logic        limit_hit;

    always_comb begin
        st_nxt   = st_r;
        wr_acc   = psel && penable && pwrite && !st_r.pready;
        rd_acc   = psel && penable && !pwrite && !st_r.pready;
        cidx     = pwdata[CMD_IDX_LSB +: 3];
        cop      = pwdata[CMD_OP_LSB +: 4];
        cpc      = pwdata[CMD_PC_BIT];
        clvl     = pwdata[CMD_LVL_LSB +: 2];
        cval     = st_r.wdata[15:0];
        auto_m   = st_r.auto_s[1];
        ev       = '0;
        mapped   = paddr[1:0] == 2'h0 && paddr <= PGR_OFS_BUSADDR;
        // Pin synchronisers
        st_nxt.auto_s  = {st_r.auto_s[0], auto_mode_pin};
        st_nxt.arrow_s = {st_r.arrow_s[0], left_arrow_pin};
        st_nxt.restart_o = 1'b0;

        // Unreleased change watch
        if (auto_m && !st_r.f60 && st_r.val != st_r.rel) begin
            st_nxt.f60 = 1'b1;
            ev[IRQ_F60] = 1'b1;
        end
        if (!auto_m && manual_run_done) begin
            st_nxt.rel = st_r.val;
            st_nxt.f60 = 1'b0;
        end

        // Bus address validity
        addr_bad = st_r.busaddr != BUSADDR_OFF &&
                   (st_r.busaddr > BUSADDR_MAX || !bus_module_max_valid);
        if (addr_bad && auto_m && !st_r.f18) begin
            st_nxt.f18 = 1'b1;
            st_nxt.restart_o = 1'b1;
            ev[IRQ_F18] = 1'b1;
        end
        // Own latch in parameter mode, so a later switch to automatic still restarts
        if (addr_bad && !auto_m && !st_r.busmsg) begin
            st_nxt.busmsg = 1'b1;
            ev[IRQ_BUSMSG] = 1'b1;
        end
        if (!addr_bad) begin
            st_nxt.f18    = 1'b0;
            st_nxt.busmsg = 1'b0;
        end
        st_nxt.show = st_r.arrow_s[1] && operating_display;

        // Restart counting
        limit_hit = 1'b0;
        if (restart_request && !st_r.lock) begin
            if (st_r.cnt_all >= st_r.lim_all) begin
                limit_hit = 1'b1;
            end else if (restart_startup_noflame && st_r.cnt_start >= st_r.lim_start) begin
                limit_hit = 1'b1;
            end else begin
                st_nxt.cnt_all = st_r.cnt_all + 3'h1;
                st_nxt.restart_o = 1'b1;
                if (restart_startup_noflame) begin
                    st_nxt.cnt_start = st_r.cnt_start + 3'h1;
                end
            end
        end
        if (unlock_event) begin
            st_nxt.lock = 1'b0;
        end
        // A limit hit in the unlock cycle still locks: the set wins
        if (limit_hit) begin
            st_nxt.lock = 1'b1;
            ev[IRQ_LOCK] = 1'b1;
        end
        if (state_operating || unlock_event) begin
            st_nxt.cnt_all   = '0;
            st_nxt.cnt_start = '0;
        end

        // APB slave, single wait state
        st_nxt.pready  = psel && penable && !st_r.pready;
        st_nxt.pslverr = psel && penable && !st_r.pready && !mapped;
        if (rd_acc) begin
            unique case (paddr)
                PGR_OFS_WDATA:   st_nxt.prdata = st_r.wdata;
                PGR_OFS_RESULT:  st_nxt.prdata = {28'h0000000, st_r.result};
                PGR_OFS_RDATA:   st_nxt.prdata = {16'h0000, st_r.rdata};
                PGR_OFS_STATUS:  st_nxt.prdata = {20'h00000, st_r.err, st_r.lock, st_r.f18, st_r.f60, auto_m};
                PGR_OFS_IRQ_ST:  st_nxt.prdata = {27'h0000000, st_r.ist};
                PGR_OFS_IRQ_MSK: st_nxt.prdata = {27'h0000000, st_r.imsk};
                PGR_OFS_CONTROL: st_nxt.prdata = {30'h00000000, st_r.level};
                PGR_OFS_RESTART: st_nxt.prdata = {20'h00000, st_r.cnt_start, st_r.cnt_all,
                                                  st_r.lim_start, st_r.lim_all};
                PGR_OFS_BUSADDR: st_nxt.prdata = {23'h000000, st_r.busaddr};
                default:         st_nxt.prdata = 32'h00000000;
            endcase
        end
        if (wr_acc) begin
            unique case (paddr)
                PGR_OFS_WDATA:   st_nxt.wdata = pwdata;
                PGR_OFS_IRQ_MSK: st_nxt.imsk = pwdata[IRQ_W-1:0];
                PGR_OFS_CONTROL: st_nxt.level = pwdata[1:0];
                PGR_OFS_RESTART: begin
                    if (pwdata[2:0] <= RESTART_MAX && pwdata[5:3] <= RESTART_MAX) begin
                        st_nxt.lim_all   = pwdata[2:0];
                        st_nxt.lim_start = pwdata[5:3];
                    end
                end
                PGR_OFS_BUSADDR: st_nxt.busaddr = pwdata[8:0];
                PGR_OFS_CMD: begin
                    st_nxt.result = RES_OK;
                    if (32'(cidx) >= NPARAM) begin
                        st_nxt.result = RES_BADOP;
                    end else if (cop == OP_READ) begin
                        st_nxt.rdata = st_r.val[cidx];
                    end else if (cop == OP_RELEASE) begin
                        if (clvl >= LVL_INTEGRATOR && st_r.level >= LVL_INTEGRATOR) begin
                            st_nxt.rel = st_r.val;
                            st_nxt.f60 = 1'b0;
                        end else begin
                            st_nxt.result = RES_LEVEL;
                        end
                    end else if (clvl < plevel(cidx) || clvl > st_r.level) begin
                        st_nxt.result = RES_LEVEL;
                    end else if (cop == OP_WRITE) begin
                        if (locked_in_op(cidx) && !state_waiting_heat) begin
                            st_nxt.result = RES_RUNNING;
                        end else if (pwidth(cidx) == PGR_W1) begin
                            if (cval > 16'h0001) st_nxt.result = RES_RANGE;
                            else st_nxt.val[cidx] = cval;
                        end else if (cval < st_r.lo[cidx] || cval > st_r.hi[cidx]) begin
                            st_nxt.result = RES_RANGE;
                        end else begin
                            st_nxt.val[cidx] = cval;
                        end
                    end else if (cop == OP_SET_LO || cop == OP_SET_HI) begin
                        if (clvl != LVL_EXPERT || !cpc || pwidth(cidx) == PGR_W1) begin
                            st_nxt.result = RES_PATH;
                        end else if (cval > fixed_hi(cidx) ||
                                     (cop == OP_SET_LO && cval > st_r.hi[cidx]) ||
                                     (cop == OP_SET_HI && cval < st_r.lo[cidx])) begin
                            st_nxt.result = RES_FIXED;
                        end else if (cop == OP_SET_LO) begin
                            st_nxt.lo[cidx] = cval;
                        end else begin
                            st_nxt.hi[cidx] = cval;
                        end
                    end else begin
                        st_nxt.result = RES_BADOP;
                    end
                    if (st_nxt.result != RES_OK) ev[IRQ_REJECT] = 1'b1;
                end
                default: ;
            endcase
        end
        // Sticky status: write one clears, a new event wins
        if (wr_acc && paddr == PGR_OFS_IRQ_ST) begin
            st_nxt.ist = st_r.ist & ~pwdata[IRQ_W-1:0];
        end
        st_nxt.ist = st_nxt.ist | ev;
        st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
        st_nxt.err = st_nxt.f60 ? ERR_UNRELEASE : ((st_nxt.f18 || st_nxt.busmsg) ? ERR_BUSADDR : ERR_NONE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r           <= '0;
            for (int i = 0; i < NPARAM; i++) begin
                st_r.hi[i] <= 16'h00ff;
            end
            st_r.busaddr   <= BUSADDR_OFF;
            st_r.lim_all   <= RESTART_MAX;
            st_r.lim_start <= RESTART_MAX;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata                = st_r.prdata;
    assign pready                = st_r.pready;
    assign pslverr               = st_r.pslverr;
    assign malfunction_interlock = st_r.f60;
    assign restart_initiate      = st_r.restart_o;
    assign lockout               = st_r.lock;
    assign error_code            = st_r.err;
    assign show_bus_address      = st_r.show;
    assign irq                   = st_r.irq;

    a_f60_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.auto_s[1] && !st_r.f60 && st_r.val != st_r.rel) |=> (malfunction_interlock && error_code == ERR_UNRELEASE))
        else $error("unreleased change did not interlock");
    a_lock_limit: assert property (@(posedge pclk) disable iff (!presetn)
        (restart_request && !lockout && st_r.cnt_all >= st_r.lim_all) |=> lockout)
        else $error("overall limit did not lock");
    a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (state_operating || unlock_event) |=> (st_r.cnt_all == 3'h0 && st_r.cnt_start == 3'h0))
        else $error("counters not cleared");
    a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.cnt_all <= RESTART_MAX && st_r.lim_all <= RESTART_MAX)
        else $error("restart count beyond range");
    a_start_bound: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.cnt_start <= st_r.cnt_all || $past(state_operating))
        else $error("start-up count exceeds overall");
    a_limits_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == PGR_OFS_CMD && cop == OP_SET_HI && cval > fixed_hi(cidx) |=> st_r.result != RES_OK)
        else $error("fixed bound not enforced");
    a_range_held: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == PGR_OFS_CMD && cop == OP_WRITE && cidx != 3'h0 && 32'(cidx) < NPARAM
        && (cval > st_r.hi[cidx] || cval < st_r.lo[cidx]) |=> $stable(st_r.val))
        else $error("out of range value taken");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    a_busaddr_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (addr_bad && st_r.auto_s[1] && !st_r.f18) |=> (restart_initiate && st_r.f18))
        else $error("bad bus address in automatic mode did not restart");
    a_busaddr_message: assert property (@(posedge pclk) disable iff (!presetn)
        (addr_bad && !st_r.auto_s[1] && !st_r.busmsg) |=> st_r.ist[IRQ_BUSMSG])
        else $error("bad bus address in parameter mode gave no message");
endmodule

// file: pgr_host_model.sv
/*
 Host side model: operator display or PC tool doing APB transfers, plus the
 operator's manual program run. Assumes pclk comes from the bench.
*/
`timescale 1ns/1ps
module pgr_host_model (
    input  wire logic                         pclk,
    output logic                              psel,
    output logic                              penable,
    output logic                              pwrite,
    output logic [pgr_pkg::PGR_AW-1:0]        paddr,
    output logic [31:0]                       pwdata,
    output logic                              manual_run_done,
    input  wire logic [31:0]                  prdata,
    input  wire logic                         pready,
    input  wire logic                         pslverr
);
    import pgr_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        manual_run_done = 1'b0;
    end
    // Request held until pready is sampled high; a hung slave ends in tmo
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic tmo);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        tmo = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data does not keep the old value
        pwdata <= ~d;
    endtask
    // Parameter mode release needs a completed manual run
    task automatic manual_run();
        @(posedge pclk) manual_run_done <= 1'b1;
        @(posedge pclk) manual_run_done <= 1'b0;
    endtask
endmodule

// file: testbench.sv
/*
 Self-checking testbench for the parameter guard block driven by a host model.
 Assumes pgr_pkg and pgr_host_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
    import pgr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, manual_run_done;
    logic [7:0]  paddr, error_code;
    logic [31:0] pwdata, prdata;
    logic        auto_mode_pin, left_arrow_pin, state_waiting_heat, state_operating, unlock_event;
    logic        restart_request, restart_startup_noflame, operating_display, bus_module_max_valid;
    logic        malfunction_interlock, restart_initiate, lockout, show_bus_address, irq;
    int          err_count, num_checks;
    pgr_param_guard dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .auto_mode_pin, .left_arrow_pin, .state_waiting_heat, .state_operating, .unlock_event,
        .restart_request, .restart_startup_noflame, .manual_run_done, .operating_display,
        .bus_module_max_valid, .malfunction_interlock, .restart_initiate, .lockout, .error_code,
        .show_bus_address, .irq);
    pgr_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .manual_run_done, .prdata,
        .pready, .pslverr);
    always #20 pclk = ~pclk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        logic t;
        host.xfer(w, a, d, q, e, t);
        if (t) begin
            err_count++;
            $display("ERROR pready exp 1 got 0");
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, q, e);
        `CHK(n, x, q)
    endtask
    // Value first, then the command; the result code is read back
    task automatic op(input logic [2:0] i, input logic [3:0] o, input logic pc, input logic [1:0] l,
                      input logic [15:0] v, input logic [3:0] x);
        wr(PGR_OFS_WDATA, {16'h0, v});
        wr(PGR_OFS_CMD, {18'h0, l, 3'h0, pc, o, 1'b0, i});
        rdchk("result", PGR_OFS_RESULT, {28'h0, x});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // First look is at the current cycle: the pulse may already stand
    task automatic pulses(input int n, output int p);
        p = 0;
        repeat (n) begin
            #1;
            if (restart_initiate === 1'b1) p++;
            @(posedge pclk);
        end
        #1;
    endtask
    task automatic unlock();
        @(posedge pclk) unlock_event <= 1'b1;
        @(posedge pclk) unlock_event <= 1'b0;
        cyc(2);
    endtask
    task automatic rst(input logic nf, input int ep, input logic el);
        int p;
        @(posedge pclk);
        restart_request <= 1'b1;
        restart_startup_noflame <= nf;
        @(posedge pclk);
        restart_request <= 1'b0;
        restart_startup_noflame <= 1'b0;
        pulses(4, p);
        `CHK("restart pulses", ep, p)
        `CHK("lockout", el, lockout)
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rdchk("restart", PGR_OFS_RESTART, 32'h2d);
        rdchk("busaddr", PGR_OFS_BUSADDR, {23'h0, BUSADDR_OFF});
        bus(1'b0, 8'h40, 32'h0, q, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, q)
        wr(PGR_OFS_CONTROL, 32'h2);
        $display("test reset done");
    endtask
    task automatic t_params();
        op(0, OP_WRITE, 0, 1, 16'h2, RES_RANGE);
        op(0, OP_WRITE, 0, 0, 16'h1, RES_LEVEL);
        op(0, OP_WRITE, 0, 1, 16'h1, RES_OK);
        op(1, OP_WRITE, 0, 2, 16'h100, RES_RANGE);
        op(1, OP_SET_HI, 0, 2, 16'h1000, RES_PATH);
        op(1, OP_SET_HI, 1, 1, 16'h1000, RES_PATH);
        op(1, OP_SET_HI, 1, 2, 16'h1000, RES_OK);
        op(1, OP_WRITE, 0, 2, 16'h100, RES_OK);
        op(1, OP_READ, 0, 2, 16'h0, RES_OK);
        rdchk("value", PGR_OFS_RDATA, 32'h100);
        op(2, OP_SET_HI, 1, 2, 16'h100, RES_FIXED);
        op(2, OP_SET_LO, 1, 2, 16'h10, RES_OK);
        op(2, OP_WRITE, 0, 2, 16'h5, RES_RANGE);
        @(posedge pclk) state_waiting_heat <= 1'b0;
        op(3, OP_WRITE, 0, 2, 16'h5, RES_RUNNING);
        @(posedge pclk) state_waiting_heat <= 1'b1;
        op(3, OP_WRITE, 0, 2, 16'h5, RES_OK);
        $display("test params done");
    endtask
    task automatic t_release();
        host.manual_run();
        @(posedge pclk) auto_mode_pin <= 1'b1;
        cyc(5);
        `CHK("interlock idle", 1'b0, malfunction_interlock)
        wr(PGR_OFS_IRQ_ST, 32'h1f);
        wr(PGR_OFS_IRQ_MSK, 32'h1f);
        op(1, OP_WRITE, 0, 2, 16'h20, RES_OK);
        cyc(3);
        `CHK("interlock", 1'b1, malfunction_interlock)
        `CHK("error code", ERR_UNRELEASE, error_code)
        `CHK("irq raised", 1'b1, irq)
        wr(PGR_OFS_IRQ_MSK, 32'h0);
        cyc(2);
        `CHK("irq masked", 1'b0, irq)
        wr(PGR_OFS_IRQ_MSK, 32'h1f);
        op(1, OP_RELEASE, 0, 0, 16'h0, RES_LEVEL);
        op(1, OP_RELEASE, 0, 1, 16'h0, RES_OK);
        cyc(2);
        `CHK("interlock released", 1'b0, malfunction_interlock)
        wr(PGR_OFS_IRQ_ST, 32'h1f);
        cyc(2);
        `CHK("irq cleared", 1'b0, irq)
        $display("test release done");
    endtask
    task automatic t_bus();
        int p;
        @(posedge pclk) auto_mode_pin <= 1'b0;
        cyc(4);
        wr(PGR_OFS_BUSADDR, 32'hfe);
        rdchk("busaddr", PGR_OFS_BUSADDR, 32'hfe);
        wr(PGR_OFS_IRQ_ST, 32'h1f);
        wr(PGR_OFS_BUSADDR, 32'hff);
        pulses(8, p);
        `CHK("param mode pulses", 0, p)
        rdchk("bus msg", PGR_OFS_IRQ_ST, 32'h1 << IRQ_BUSMSG);
        @(posedge pclk) auto_mode_pin <= 1'b1;
        pulses(10, p);
        `CHK("auto pulses", 1, p)
        `CHK("error code", ERR_BUSADDR, error_code)
        wr(PGR_OFS_BUSADDR, 32'h10);
        @(posedge pclk) left_arrow_pin <= 1'b1;
        cyc(5);
        `CHK("show addr", 1'b1, show_bus_address)
        @(posedge pclk) left_arrow_pin <= 1'b0;
        cyc(5);
        `CHK("hide addr", 1'b0, show_bus_address)
        $display("test bus done");
    endtask
    task automatic t_restart();
        unlock();
        wr(PGR_OFS_RESTART, 32'h0a);
        wr(PGR_OFS_RESTART, 32'h06);
        rdchk("limits", PGR_OFS_RESTART, 32'h0a);
        rst(0, 1, 0);
        rst(0, 1, 0);
        rst(0, 0, 1);
        rdchk("counts", PGR_OFS_RESTART, 32'h8a);
        unlock();
        `CHK("unlocked", 1'b0, lockout)
        rdchk("cleared", PGR_OFS_RESTART, 32'h0a);
        rst(1, 1, 0);
        rst(1, 0, 1);
        unlock();
        rst(0, 1, 0);
        @(posedge pclk) state_operating <= 1'b1;
        @(posedge pclk) state_operating <= 1'b0;
        rdchk("oper clear", PGR_OFS_RESTART, 32'h0a);
        wr(PGR_OFS_RESTART, 32'h0);
        rst(0, 0, 1);
        unlock();
        $display("test restart done");
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {auto_mode_pin, left_arrow_pin, state_operating, unlock_event} = 4'h0;
        {restart_request, restart_startup_noflame} = 2'h0;
        {state_waiting_heat, operating_display, bus_module_max_valid} = 3'h7;
        err_count = 0;
        num_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_params();
        t_release();
        t_bus();
        t_restart();
        finish_test();
    end
endmodule
